// *** design/prm_map.svh ***
// Register offsets, field positions and reset values of the paged register bank
`ifndef PRM_MAP_SVH
`define PRM_MAP_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define PRM_NUM_PAGES 8
`define PRM_REGS_PER_PAGE 8
`define PRM_NUM_REGS 64

// ----------------------------------------
// Register offsets (linear register address)
// ----------------------------------------
`define PRM_OFS_PAGE_SELECT 6'h00
`define PRM_OFS_FILL_COUNT 6'h04
`define PRM_OFS_IRQ_ENABLE 6'h06
`define PRM_OFS_IRQ_REQUEST 6'h07
`define PRM_OFS_GENERAL_CONTROL 6'h09
`define PRM_OFS_ERROR_FLAGS 6'h0A
`define PRM_OFS_COLLISION_POS 6'h0B
`define PRM_OFS_CHECKSUM_LOW 6'h0E
`define PRM_OFS_CHECKSUM_HIGH 6'h0F
`define PRM_OFS_TX_PIN_CONTROL 6'h11
`define PRM_OFS_MOD_CONDUCTANCE 6'h13
`define PRM_OFS_RX_DELAY 6'h21
`define PRM_OFS_RSVD_FIRST 6'h31
`define PRM_OFS_RSVD_LAST 6'h37

// ----------------------------------------
// Fields
// ----------------------------------------
`define PRM_PAGE_USE_PAGING_BIT 7
`define PRM_TXC_FORCE_FULL_BIT 4
`define PRM_MODC_SETTING_MSB 5
`define PRM_MODC_FULL_DEPTH 6'h3F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PRM_RST_PAGE_SELECT 8'h80
`define PRM_RST_TX_PIN_CONTROL 8'h58
`define PRM_RST_GENERAL_CONTROL 8'h00
`define PRM_RST_DEFAULT 8'h00

`endif

// *** design/prm_pkg.sv ***
// Types shared by the paged register bank
`default_nettype none
package prm_pkg;

  // ----------------------------------------
  // Host register port
  // ----------------------------------------
  typedef struct packed {
    logic       sel;
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } prm_bus_req_s;

  // ----------------------------------------
  // Status arriving from the device core
  // ----------------------------------------
  typedef struct packed {
    logic [6:0]  buffer_fill_count;
    logic [7:0]  irq_events;
    logic        cmd_done;
    logic [7:0]  command_error_flags;
    logic        collision_seen;
    logic [7:0]  collision_position;
    logic        link_type_b;
    logic [15:0] checksum_result;
    logic        tx_done;
  } prm_core_stat_s;

  // ----------------------------------------
  // Controls going to the device core
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] transmit_pin_control;
    logic [5:0] modulation_conductance_eff;
    logic [7:0] general_control;
    logic       rx_enable;
  } prm_core_ctl_s;

  typedef enum logic [1:0] {
    PRM_RXD_IDLE = 2'b00,
    PRM_RXD_WAIT = 2'b01,
    PRM_RXD_FIRE = 2'b11
  } prm_rxd_state_e;

endpackage : prm_pkg
`default_nettype wire

// *** design/prm_addr_decode.sv ***
// Forms the linear register address from the bus address and the page register
`default_nettype none
`include "prm_map.svh"
module prm_addr_decode (
  // Bus side
  input wire logic [5:0] addr_in,
  input wire logic mux_bus_in,
  // Page register
  input wire logic [7:0] page_select_in,
  // Decoded
  output logic [5:0] lin_addr_out,
  output logic is_page_out
);
  import prm_pkg::*;

  logic use_paging;

  always_comb begin
    // Dedicated bus always pages; multiplexed bus pages only when enabled
    use_paging = !mux_bus_in || page_select_in[`PRM_PAGE_USE_PAGING_BIT];
    if (use_paging) begin
      lin_addr_out = {page_select_in[2:0], addr_in[2:0]};
    end else begin
      lin_addr_out = addr_in;
    end
    // Page register sits at the first slot of every page
    is_page_out = (lin_addr_out[2:0] == 3'h0);
  end

endmodule : prm_addr_decode
`default_nettype wire

// *** design/prm_regbank.sv ***
// Paged register bank: host access, core status capture and control outputs
`default_nettype none
`include "prm_map.svh"
// What this block does
// - 64 byte registers in eight pages of eight
// - Page register at every page start, resets 0x80
// - Page register reachable from any page
// - Dedicated bus: three lines, page register pages
// - Multiplexed bus: six lines, paged or linear
// - Transmit pin control at 0x11, resets 0x58
// - General control resets to zero
// - Forced full depth overrides modulation conductance
// - Type B never updates collision position; the last captured one stays readable
// - Fill count of buffer readable
// - Enable bits gate request flags onto interrupt
// - Error register holds last command outcome
// - Programmable delay after transmit before receive
// - Checksum result as low and high bytes
// - Page six 0x31 to 0x37 reserved
module prm_regbank #(
  parameter int DELAY_STEP_CYCLES = 1
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // Host register port
  input wire prm_pkg::prm_bus_req_s bus_in,
  input wire logic mux_bus_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // Core status and control
  input wire prm_pkg::prm_core_stat_s core_in,
  output prm_pkg::prm_core_ctl_s ctl_out,
  output logic irq_out
);
  import prm_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic [7:0] page_q;
  logic [7:0] page_d;
  logic [5:0] lin_addr;
  logic is_page;
  logic wr_hit;
  logic rd_hit;
  logic is_rsvd;

  prm_addr_decode u_decode (
    .addr_in(bus_in.addr),
    .mux_bus_in(mux_bus_in),
    .page_select_in(page_q),
    .lin_addr_out(lin_addr),
    .is_page_out(is_page)
  );

  assign wr_hit = bus_in.sel && bus_in.wr;
  assign rd_hit = bus_in.sel && bus_in.rd && !bus_in.wr;
  assign is_rsvd = (lin_addr >= `PRM_OFS_RSVD_FIRST) && (lin_addr <= `PRM_OFS_RSVD_LAST);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] regs_q [`PRM_NUM_REGS];
  logic [7:0] regs_d [`PRM_NUM_REGS];
  logic [7:0] irq_req_q;
  logic [7:0] irq_req_d;
  logic [7:0] err_q;
  logic [7:0] err_d;
  logic [7:0] coll_q;
  logic [7:0] coll_d;

  function automatic logic [7:0] reset_value(input int idx);
    logic [7:0] v;
    v = `PRM_RST_DEFAULT;
    if (idx == int'(`PRM_OFS_TX_PIN_CONTROL)) begin
      v = `PRM_RST_TX_PIN_CONTROL;
    end else if (idx == int'(`PRM_OFS_GENERAL_CONTROL)) begin
      v = `PRM_RST_GENERAL_CONTROL;
    end
    return v;
  endfunction : reset_value

  always_comb begin
    page_d = page_q;
    for (int i = 0; i < `PRM_NUM_REGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (wr_hit) begin
      if (is_page) begin
        page_d = bus_in.wdata;
      end else if (!is_rsvd) begin
        regs_d[lin_addr] = bus_in.wdata;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      page_q <= `PRM_RST_PAGE_SELECT;
      for (int i = 0; i < `PRM_NUM_REGS; i++) begin
        regs_q[i] <= reset_value(i);
      end
    end else begin
      page_q <= page_d;
      for (int i = 0; i < `PRM_NUM_REGS; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // ----------------------------------------
  // Core status capture
  // ----------------------------------------
  logic irq_req_wr;

  assign irq_req_wr = wr_hit && !is_page && (lin_addr == `PRM_OFS_IRQ_REQUEST);

  always_comb begin
    // Writing one clears a flag; a new event in the same cycle wins
    irq_req_d = irq_req_q;
    if (irq_req_wr) begin
      irq_req_d = irq_req_d & ~bus_in.wdata;
    end
    irq_req_d = irq_req_d | core_in.irq_events;
    err_d = core_in.cmd_done ? core_in.command_error_flags : err_q;
    coll_d = coll_q;
    if (core_in.collision_seen && !core_in.link_type_b) begin
      coll_d = core_in.collision_position;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_req_q <= 8'h00;
      err_q <= 8'h00;
      coll_q <= 8'h00;
    end else begin
      irq_req_q <= irq_req_d;
      err_q <= err_d;
      coll_q <= coll_d;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic rd_valid_q;

  always_comb begin
    rd_data_d = rd_data_q;
    if (rd_hit) begin
      if (is_page) begin
        rd_data_d = page_q;
      end else if (is_rsvd) begin
        rd_data_d = 8'h00;
      end else begin
        case (lin_addr)
          `PRM_OFS_FILL_COUNT: rd_data_d = {1'b0, core_in.buffer_fill_count};
          `PRM_OFS_IRQ_REQUEST: rd_data_d = irq_req_q;
          `PRM_OFS_ERROR_FLAGS: rd_data_d = err_q;
          `PRM_OFS_COLLISION_POS: rd_data_d = coll_q;
          `PRM_OFS_CHECKSUM_LOW: rd_data_d = core_in.checksum_result[7:0];
          `PRM_OFS_CHECKSUM_HIGH: rd_data_d = core_in.checksum_result[15:8];
          default: rd_data_d = regs_q[lin_addr];
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_hit;
    end
  end

  assign rd_data_out = rd_data_q;
  assign rd_valid_out = rd_valid_q;

  // ----------------------------------------
  // Interrupt and control outputs
  // ----------------------------------------
  prm_rxd_state_e rxd_q;
  prm_rxd_state_e rxd_d;
  logic [7:0] txc;
  logic force_full;

  assign irq_out = |(irq_req_q & regs_q[`PRM_OFS_IRQ_ENABLE]);
  assign txc = regs_q[`PRM_OFS_TX_PIN_CONTROL];
  assign force_full = txc[`PRM_TXC_FORCE_FULL_BIT];

  always_comb begin
    ctl_out.transmit_pin_control = txc;
    ctl_out.general_control = regs_q[`PRM_OFS_GENERAL_CONTROL];
    if (force_full) begin
      ctl_out.modulation_conductance_eff = `PRM_MODC_FULL_DEPTH;
    end else begin
      ctl_out.modulation_conductance_eff =
        regs_q[`PRM_OFS_MOD_CONDUCTANCE][`PRM_MODC_SETTING_MSB:0];
    end
    ctl_out.rx_enable = rxd_q == PRM_RXD_FIRE;
  end

  // ----------------------------------------
  // Receive delay after transmit
  // ----------------------------------------
  logic [15:0] rxd_cnt_q;
  logic [15:0] rxd_cnt_d;
  logic [15:0] rxd_total;

  assign rxd_total = 16'(regs_q[`PRM_OFS_RX_DELAY]) * 16'(DELAY_STEP_CYCLES);

  always_comb begin
    rxd_d = rxd_q;
    rxd_cnt_d = rxd_cnt_q;
    case (rxd_q)
      PRM_RXD_IDLE: begin
        if (core_in.tx_done) begin
          rxd_cnt_d = rxd_total;
          rxd_d = (rxd_total == 16'h0000) ? PRM_RXD_FIRE : PRM_RXD_WAIT;
        end
      end
      PRM_RXD_WAIT: begin
        if (rxd_cnt_q <= 16'h0001) begin
          rxd_cnt_d = 16'h0000;
          rxd_d = PRM_RXD_FIRE;
        end else begin
          rxd_cnt_d = rxd_cnt_q - 16'h0001;
        end
      end
      PRM_RXD_FIRE: begin
        rxd_d = PRM_RXD_IDLE;
      end
      default: begin
        rxd_d = PRM_RXD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rxd_q <= PRM_RXD_IDLE;
      rxd_cnt_q <= 16'h0000;
    end else begin
      rxd_q <= rxd_d;
      rxd_cnt_q <= rxd_cnt_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  chk_page_write_any: assert property (
    wr_hit && is_page |=> page_q == $past(bus_in.wdata))
    else $error("page register write lost");

  chk_page_read_mirror: assert property (
    rd_hit && is_page |=> rd_valid_out && rd_data_out == $past(page_q))
    else $error("page register read mismatch");

  chk_linear_addr: assert property (
    mux_bus_in && !page_q[`PRM_PAGE_USE_PAGING_BIT] |-> lin_addr == bus_in.addr)
    else $error("linear address not taken from bus");

  chk_paged_addr: assert property (
    !mux_bus_in |-> lin_addr == {page_q[2:0], bus_in.addr[2:0]})
    else $error("paged address not formed from page register");

  chk_force_full: assert property (
    force_full |-> ctl_out.modulation_conductance_eff == `PRM_MODC_FULL_DEPTH)
    else $error("modulation setting not overridden");

  chk_type_b_coll: assert property (
    core_in.link_type_b |=> coll_q == $past(coll_q))
    else $error("collision position changed in type B");

  chk_irq_gate: assert property (
    regs_q[`PRM_OFS_IRQ_ENABLE] == 8'h00 |-> !irq_out)
    else $error("interrupt not gated by enables");

  chk_error_capture: assert property (
    core_in.cmd_done |=> err_q == $past(core_in.command_error_flags))
    else $error("error flags not captured");

  chk_rx_delay_zero: assert property (
    rxd_q == PRM_RXD_IDLE && core_in.tx_done && rxd_total == 16'h0000 |=> ctl_out.rx_enable)
    else $error("receiver not enabled after zero delay");

  chk_rx_delay_one: assert property (
    rxd_q == PRM_RXD_IDLE && core_in.tx_done && rxd_total == 16'h0001
    |=> !ctl_out.rx_enable ##1 ctl_out.rx_enable)
    else $error("receiver enable timing wrong");

  chk_rsvd_read: assert property (
    rd_hit && !is_page && is_rsvd |=> rd_data_out == 8'h00)
    else $error("reserved register read not zero");

  cov_linear_write: cover property (wr_hit && mux_bus_in && !page_q[7]);
  cov_rx_delay: cover property (rxd_q == PRM_RXD_WAIT ##[1:20] ctl_out.rx_enable);
  cov_irq_raise: cover property ($rose(irq_out));

endmodule : prm_regbank
`default_nettype wire

// *** testbench/prm_core_model.sv ***
// Behavioural device core that feeds status into the register bank
`default_nettype none
module prm_core_model (
  // Clock
  input wire logic sys_clk_in,
  // Status towards the bank
  output var prm_pkg::prm_core_stat_s core_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import prm_pkg::*;

  initial core_out = '0;

  // ----------------------------------------
  // Status driver
  // ----------------------------------------
  // Shows one status set for a cycle; pulses drop afterwards, levels stay
  task automatic drive(input prm_core_stat_s s);
    @(posedge sys_clk_in) core_out <= s;
    @(posedge sys_clk_in) begin
      core_out.irq_events <= 8'h00;
      core_out.cmd_done <= 1'b0;
      core_out.collision_seen <= 1'b0;
      core_out.tx_done <= 1'b0;
    end
  endtask : drive
endmodule : prm_core_model
`default_nettype wire

// *** testbench/paged_register_map_access_tb.sv ***
// Self-checking bench for the paged register bank
`default_nettype none
`include "prm_map.svh"
`define CHK(nm, ex, got) begin \
  total_checks++; \
  if ((got) !== (ex)) begin \
    n_fail++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module paged_register_map_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import prm_pkg::*;
  localparam int STEP = 1;
  logic sys_clk_in, reset_in, mux_bus_in, rd_valid_out, irq_out;
  logic [7:0] rd_data_out;
  prm_bus_req_s bus_in;
  prm_core_stat_s core_in, cs;
  prm_core_ctl_s ctl_out;
  int n_fail, total_checks, n;

  prm_regbank #(.DELAY_STEP_CYCLES(STEP)) i_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .bus_in(bus_in), .mux_bus_in(mux_bus_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .core_in(core_in), .ctl_out(ctl_out), .irq_out(irq_out));
  prm_core_model i_core (.sys_clk_in(sys_clk_in), .core_out(core_in));

  // ----------------------------------------
  // Host access tasks
  // ----------------------------------------
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk_in) bus_in <= '{1'b1, 1'b1, 1'b0, a, d};
    @(posedge sys_clk_in) bus_in <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] ex, input string nm);
    @(posedge sys_clk_in) bus_in <= '{1'b1, 1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk_in) bus_in <= '0;
    #1;
    `CHK(nm, ex, rd_data_out)
    `CHK("rd_valid", 1'b1, rd_valid_out)
  endtask : rd

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_fail++;
    tally_and_finish;
  end

  // ----------------------------------------
  // Tests; factory preset places are checked after reset, then written
  // ----------------------------------------
  initial begin
    reset_in = 1'b1;
    mux_bus_in = 1'b0;
    bus_in = '0;
    n_fail = 0;
    total_checks = 0;
    cs = '0;
    repeat (8) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    #1;
    `CHK("txc_rst", `PRM_RST_TX_PIN_CONTROL, ctl_out.transmit_pin_control)
    `CHK("gctl_rst", `PRM_RST_GENERAL_CONTROL, ctl_out.general_control)
    `CHK("mod_rst", `PRM_MODC_FULL_DEPTH, ctl_out.modulation_conductance_eff)
    rd(`PRM_OFS_PAGE_SELECT, `PRM_RST_PAGE_SELECT, "page_rst");
    // Dedicated bus: visit every page through the page mirror
    for (int p = 0; p < 8; p++) begin
      wr(6'h00, {5'h10, p[2:0]});
      rd(6'h00, {5'h10, p[2:0]}, "page_mirror");
      wr(6'h05, 8'h50 + 8'(p));
    end
    // Multiplexed bus, linear addressing
    @(posedge sys_clk_in) mux_bus_in <= 1'b1;
    wr(6'h08, 8'h00);
    rd(6'h38, 8'h00, "page_linear");
    for (int p = 0; p < 8; p++) begin
      rd({p[2:0], 3'd5}, (p == 6) ? 8'h00 : 8'h50 + 8'(p), "linear_map");
    end
    for (int a = 'h31; a <= 'h37; a++) begin
      wr(6'(a), 8'hFF);
      rd(6'(a), 8'h00, "reserved");
    end
    wr(`PRM_OFS_MOD_CONDUCTANCE, 8'h2A);
    `CHK("mod_forced", 6'h3F, ctl_out.modulation_conductance_eff)
    wr(`PRM_OFS_TX_PIN_CONTROL, 8'h48);
    `CHK("txc", 8'h48, ctl_out.transmit_pin_control)
    `CHK("mod_free", 6'h2A, ctl_out.modulation_conductance_eff)
    wr(`PRM_OFS_GENERAL_CONTROL, 8'hA5);
    `CHK("gctl", 8'hA5, ctl_out.general_control)
    // Multiplexed paged, then dedicated with upper lines ignored
    wr(6'h00, 8'h82);
    rd(6'h03, 8'h2A, "mux_paged");
    @(posedge sys_clk_in) mux_bus_in <= 1'b0;
    rd(6'h3B, 8'h2A, "dedicated");
    @(posedge sys_clk_in) mux_bus_in <= 1'b1;
    wr(6'h00, 8'h00);
    // Core status capture
    cs.buffer_fill_count = 7'd64;
    cs.checksum_result = 16'hBEEF;
    cs.command_error_flags = 8'h5A;
    cs.cmd_done = 1'b1;
    cs.collision_position = 8'h12;
    cs.collision_seen = 1'b1;
    cs.irq_events = 8'h04;
    i_core.drive(cs);
    rd(`PRM_OFS_FILL_COUNT, 8'h40, "fill");
    rd(`PRM_OFS_CHECKSUM_LOW, 8'hEF, "crc_lo");
    rd(`PRM_OFS_CHECKSUM_HIGH, 8'hBE, "crc_hi");
    rd(`PRM_OFS_ERROR_FLAGS, 8'h5A, "err");
    rd(`PRM_OFS_COLLISION_POS, 8'h12, "coll_a");
    `CHK("irq_masked", 1'b0, irq_out)
    rd(`PRM_OFS_IRQ_REQUEST, 8'h04, "irq_req");
    cs.cmd_done = 1'b0;
    cs.command_error_flags = 8'hC3;
    cs.link_type_b = 1'b1;
    cs.collision_position = 8'h34;
    cs.irq_events = 8'h00;
    i_core.drive(cs);
    rd(`PRM_OFS_ERROR_FLAGS, 8'h5A, "err_hold");
    rd(`PRM_OFS_COLLISION_POS, 8'h12, "coll_b");
    wr(`PRM_OFS_IRQ_ENABLE, 8'h04);
    `CHK("irq_on", 1'b1, irq_out)
    wr(`PRM_OFS_IRQ_REQUEST, 8'h04);
    `CHK("irq_clr", 1'b0, irq_out)
    // Receive delay after transmit
    cs.collision_seen = 1'b0;
    cs.tx_done = 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(`PRM_OFS_RX_DELAY, (i == 0) ? 8'h00 : 8'h03);
      i_core.drive(cs);
      n = 0;
      #1;
      while (ctl_out.rx_enable !== 1'b1 && n < 50) begin
        @(posedge sys_clk_in);
        #1;
        n++;
      end
      `CHK("rx_delay", ((i == 0) ? 0 : 3) * STEP, n)
    end
    tally_and_finish;
  end
endmodule : paged_register_map_access_tb
`default_nettype wire
